// >>> dv/iod_core_model.sv
// Execution-unit model that issues accesses to the low I/O register bank
`timescale 1ns/1ps

module iod_core_model (
	input  wire logic        clk,         // Core clock
	output iod_pkg::iod_op_t op,          // Access class
	output logic [7:0]       addr,        // I/O or data address
	output logic [2:0]       bit_sel,     // Bit for bit ops and skips
	output logic             skip_on_set, // Skip polarity
	output logic [7:0]       wdata,       // Write data
	input  wire logic [7:0]  rdata,       // Read data from the bank
	input  wire logic        rvalid,      // Read answered
	input  wire logic        skip,        // Skip result
	input  wire logic        ext_sel      // Access left for extended space
);
	logic [7:0] got_data;  // Read data taken one cycle after the request
	logic [2:0] got_flags; // Taken rvalid, skip, ext_sel

	// ****************************************
	// Idle bus at time zero
	// ****************************************
	initial begin
		op = iod_pkg::IOD_OP_NONE;
		addr = 8'h00;
		bit_sel = 3'h0;
		skip_on_set = 1'b0;
		wdata = 8'h00;
	end

	// ****************************************
	// One access, launched off the falling edge
	// ****************************************
	task automatic xfer(input iod_pkg::iod_op_t o, input logic [7:0] a, input logic [2:0] b,
		input logic pol, input logic [7:0] d);
		@(negedge clk);
		// callers hand only zeroed reserved bits and no reserved write address
		op = o;
		addr = a;
		bit_sel = b;
		skip_on_set = pol;
		wdata = d;
		@(negedge clk);
		got_data = rdata;
		got_flags = {rvalid, skip, ext_sel};
		// Released address, bit and data lines show the inverse so a stale value is never mistaken for a request
		op = iod_pkg::IOD_OP_NONE;
		addr = ~a;
		bit_sel = ~b;
		wdata = ~d;
	endtask
endmodule

// >>> dv/tb.sv
// Self-checking testbench for the low I/O register bank
`timescale 1ns/1ps

module tb;
	logic clk;                 // Core clock
	logic sys_rst;             // Reset, active high
	iod_pkg::iod_op_t op;      // Access class from the model
	logic [7:0] addr, wdata;   // Address and write data
	logic [2:0] bit_sel;       // Bit select
	logic skip_on_set;         // Skip polarity
	logic [7:0] pin_b, pin_c, pin_d;            // Pin levels
	logic [7:0] t0_evt, t1_evt, t2_evt, pc_evt, ex_evt; // Flag set pulses
	logic [7:0] rdata, port_b_out, port_b_dir, port_c_out, port_c_dir, port_d_out, port_d_dir;
	logic rvalid, skip, ext_sel; // Answer strobes
	logic [1:0] ext_irq_mask;  // External enables
	int n_mismatch = 0;        // Mismatches seen
	int n_compared = 0;        // Comparisons made

	iod_regs i_dut (.clk(clk), .sys_rst(sys_rst), .op(op), .addr(addr), .bit_sel(bit_sel),
		.skip_on_set(skip_on_set), .wdata(wdata), .pin_b(pin_b), .pin_c(pin_c), .pin_d(pin_d),
		.t0_evt(t0_evt), .t1_evt(t1_evt), .t2_evt(t2_evt), .pc_evt(pc_evt), .ex_evt(ex_evt),
		.rdata(rdata), .rvalid(rvalid), .skip(skip), .ext_sel(ext_sel), .port_b_out(port_b_out),
		.port_b_dir(port_b_dir), .port_c_out(port_c_out), .port_c_dir(port_c_dir),
		.port_d_out(port_d_out), .port_d_dir(port_d_dir), .ext_irq_mask(ext_irq_mask));

	iod_core_model i_core (.clk(clk), .op(op), .addr(addr), .bit_sel(bit_sel), .skip_on_set(skip_on_set),
		.wdata(wdata), .rdata(rdata), .rvalid(rvalid), .skip(skip), .ext_sel(ext_sel));

	// ****************************************
	// Clock, 8 ns period
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****************************************
	// Shared helpers
	// ****************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Expected answer strobes are {rvalid, skip, ext_sel}
	task automatic acc(input iod_pkg::iod_op_t o, input logic [7:0] a, input logic [2:0] b, input logic p,
		input logic [7:0] d, input logic [2:0] fl, input logic [7:0] exp);
		i_core.xfer(o, a, b, p, d);
		chk({5'h0, i_core.got_flags}, {5'h0, fl});
		chk(i_core.got_data, exp);
	endtask
	// Event pulses last one clock; only the selected source fires
	task automatic pulse(input int i, input logic [7:0] v);
		@(negedge clk);
		t0_evt = (i == 0) ? v : 8'h00;
		t1_evt = (i == 1) ? v : 8'h00;
		t2_evt = (i == 2) ? v : 8'h00;
		pc_evt = (i == 3) ? v : 8'h00;
		ex_evt = (i == 4) ? v : 8'h00;
		@(negedge clk);
		{t0_evt, t1_evt, t2_evt, pc_evt, ex_evt} = '0;
	endtask
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	// Latches and directions by direct access, read back and at the pins
	task automatic t_ports();
		logic [7:0] a [6] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0a, 8'h0b};
		logic [7:0] v [6] = '{8'h3c, 8'ha5, 8'h55, 8'h2a, 8'h0f, 8'hf0};
		foreach (a[i]) acc(iod_pkg::IOD_OP_OUT, a[i], 3'h0, 1'b0, v[i], 3'b000, 8'h00);
		foreach (a[i]) acc(iod_pkg::IOD_OP_IN, a[i], 3'h0, 1'b0, 8'h00, 3'b100, v[i]);
		chk(port_b_dir, 8'h3c);
		chk(port_c_out, 8'h2a);
		chk(port_d_out, 8'hf0);
		chk(port_c_dir, 8'h55);
		chk(port_d_dir, 8'h0f);
	endtask
	// Data-space offset, refusal below it, extended space and reserved reads
	task automatic t_space();
		acc(iod_pkg::IOD_OP_ST, 8'h25, 3'h0, 1'b0, 8'h69, 3'b000, 8'h00);
		chk(port_b_out, 8'h69);
		acc(iod_pkg::IOD_OP_LD, 8'h2a, 3'h0, 1'b0, 8'h00, 3'b100, 8'h0f);
		acc(iod_pkg::IOD_OP_LD, 8'h05, 3'h0, 1'b0, 8'h00, 3'b000, 8'h00);
		acc(iod_pkg::IOD_OP_ST, 8'h60, 3'h0, 1'b0, 8'h11, 3'b001, 8'h00);
		acc(iod_pkg::IOD_OP_LD, 8'hff, 3'h0, 1'b0, 8'h00, 3'b001, 8'h00);
		acc(iod_pkg::IOD_OP_IN, 8'h0c, 3'h0, 1'b0, 8'h00, 3'b100, 8'h00);
		acc(iod_pkg::IOD_OP_IN, 8'h10, 3'h0, 1'b0, 8'h00, 3'b100, 8'h00);
		chk(port_b_out, 8'h69);
	endtask
	// Flag layouts, write-zero ignored, write-one clears
	task automatic t_flags();
		logic [7:0] a [5] = '{8'h15, 8'h16, 8'h17, 8'h1b, 8'h1c};
		logic [7:0] m [5] = '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03};
		foreach (a[i]) begin
			pulse(i, 8'hff);
			acc(iod_pkg::IOD_OP_IN, a[i], 3'h0, 1'b0, 8'h00, 3'b100, m[i]);
			acc(iod_pkg::IOD_OP_OUT, a[i], 3'h0, 1'b0, 8'h00, 3'b000, 8'h00);
			acc(iod_pkg::IOD_OP_OUT, a[i], 3'h0, 1'b0, 8'h01, 3'b000, 8'h00);
			acc(iod_pkg::IOD_OP_IN, a[i], 3'h0, 1'b0, 8'h00, 3'b100, m[i] & 8'hfe);
			acc(iod_pkg::IOD_OP_OUT, a[i], 3'h0, 1'b0, m[i], 3'b000, 8'h00);
			acc(iod_pkg::IOD_OP_IN, a[i], 3'h0, 1'b0, 8'h00, 3'b100, 8'h00);
		end
	endtask
	// Bit ops on a latch and on a flag register, out-of-range ignored
	task automatic t_bits();
		acc(iod_pkg::IOD_OP_BSET, 8'h05, 3'h7, 1'b0, 8'h00, 3'b000, 8'h00);
		acc(iod_pkg::IOD_OP_BCLR, 8'h05, 3'h0, 1'b0, 8'h00, 3'b000, 8'h00);
		chk(port_b_out, 8'he8);
		acc(iod_pkg::IOD_OP_BSET, 8'h25, 3'h0, 1'b0, 8'h00, 3'b000, 8'h00);
		chk(port_b_out, 8'he8);
		pulse(4, 8'h03);
		acc(iod_pkg::IOD_OP_BSET, 8'h1c, 3'h1, 1'b0, 8'h00, 3'b000, 8'h00);
		acc(iod_pkg::IOD_OP_BCLR, 8'h1c, 3'h1, 1'b0, 8'h00, 3'b000, 8'h00);
		acc(iod_pkg::IOD_OP_IN, 8'h1c, 3'h0, 1'b0, 8'h00, 3'b100, 8'h01);
		acc(iod_pkg::IOD_OP_OUT, 8'h1c, 3'h0, 1'b0, 8'h01, 3'b000, 8'h00);
	endtask
	// Skip tests of both polarities, and out of range
	task automatic t_skip();
		acc(iod_pkg::IOD_OP_SKIP, 8'h05, 3'h3, 1'b1, 8'h00, 3'b110, 8'he8);
		acc(iod_pkg::IOD_OP_SKIP, 8'h05, 3'h3, 1'b0, 8'h00, 3'b100, 8'he8);
		acc(iod_pkg::IOD_OP_SKIP, 8'h05, 3'h4, 1'b0, 8'h00, 3'b110, 8'he8);
		acc(iod_pkg::IOD_OP_SKIP, 8'h25, 3'h3, 1'b1, 8'h00, 3'b000, 8'h00);
	endtask
	// Pin inputs after synchronising, mask register
	task automatic t_pins();
		pin_b = 8'h5a;
		pin_c = 8'hff;
		pin_d = 8'h81;
		repeat (3) @(negedge clk);
		acc(iod_pkg::IOD_OP_IN, 8'h03, 3'h0, 1'b0, 8'h00, 3'b100, 8'h5a);
		acc(iod_pkg::IOD_OP_IN, 8'h06, 3'h0, 1'b0, 8'h00, 3'b100, 8'h7f);
		acc(iod_pkg::IOD_OP_LD, 8'h29, 3'h0, 1'b0, 8'h00, 3'b100, 8'h81);
		acc(iod_pkg::IOD_OP_OUT, 8'h1d, 3'h0, 1'b0, 8'h02, 3'b000, 8'h00);
		chk({6'h0, ext_irq_mask}, 8'h02);
		acc(iod_pkg::IOD_OP_IN, 8'h1d, 3'h0, 1'b0, 8'h00, 3'b100, 8'h02);
	endtask

	// ****************************************
	// Main sequence, reset held 20 cycles
	// ****************************************
	initial begin
		sys_rst = 1'b1;
		{pin_b, pin_c, pin_d, t0_evt, t1_evt, t2_evt, pc_evt, ex_evt} = '0;
		repeat (20) @(negedge clk);
		sys_rst = 1'b0;
		chk(port_d_dir, 8'h00);
		t_ports();
		t_space();
		t_flags();
		t_bits();
		t_skip();
		t_pins();
		finish_test();
	end

	// Watchdog well beyond the 165 or so cycles the tests take
	initial begin
		#50000;
		n_mismatch++;
		finish_test();
	end
endmodule

// >>> rtl/iod_cfg.svh
// Constants for the low I/O register space decoder
// Notes on behaviour
// - Bit set/clear only reach addresses 0x00-0x1F
// - Skip-if-bit tests evaluate one bit there
// - Bit set/clear touches only addressed bit
// - Flags clear on writing one, zero ignored
// - Direct in/out decode addresses 0x00-0x3F
// - Data-space address is I/O address plus 0x20
// - Extended 0x60-0xFF only by load/store
// - Pin-change flags in bits two to zero
// - Timer1 flags in bits five, two, one, zero
// - Timer0/2 flags in bits two, one, zero
// - Ports: pin, direction, latch ascending addresses
`ifndef IOD_CFG_SVH
`define IOD_CFG_SVH

// ****************************************
// Register offsets (I/O addresses)
// ****************************************
`define IOD_B_IN_ADDR   6'h03
`define IOD_B_DIR_ADDR  6'h04
`define IOD_B_LAT_ADDR  6'h05
`define IOD_C_IN_ADDR   6'h06
`define IOD_C_DIR_ADDR  6'h07
`define IOD_C_LAT_ADDR  6'h08
`define IOD_D_IN_ADDR   6'h09
`define IOD_D_DIR_ADDR  6'h0a
`define IOD_D_LAT_ADDR  6'h0b
`define IOD_T0FLG_ADDR  6'h15
`define IOD_T1FLG_ADDR  6'h16
`define IOD_T2FLG_ADDR  6'h17
`define IOD_PCFLG_ADDR  6'h1b
`define IOD_EXFLG_ADDR  6'h1c
`define IOD_EXMSK_ADDR  6'h1d

// ****************************************
// Address space limits
// ****************************************
`define IOD_BIT_TOP     6'h1f
`define IOD_DS_OFFSET   8'h20
`define IOD_DS_IO_TOP   8'h5f
`define IOD_EXT_BASE    8'h60

// ****************************************
// Implemented bit masks (others read zero)
// ****************************************
`define IOD_C_MASK      8'h7f
`define IOD_TMR_MASK    8'h07
`define IOD_T1_MASK     8'h27
`define IOD_PC_MASK     8'h07
`define IOD_EX_MASK     8'h03
`define IOD_RST_VAL     8'h00

`endif

// >>> rtl/iod_pkg.sv
// Types for the low I/O register space decoder
package iod_pkg;
	// Access class issued by the execution unit
	typedef enum logic [2:0] {
		IOD_OP_NONE  = 3'b000,
		IOD_OP_IN    = 3'b001,
		IOD_OP_OUT   = 3'b010,
		IOD_OP_LD    = 3'b011,
		IOD_OP_ST    = 3'b100,
		IOD_OP_BSET  = 3'b101,
		IOD_OP_BCLR  = 3'b110,
		IOD_OP_SKIP  = 3'b111
	} iod_op_t;
endpackage

// >>> rtl/iod_regs.sv
// Low I/O register bank with direct, bit and data-space decode
`timescale 1ns/1ps
`include "iod_cfg.svh"

module iod_regs (
	input  wire logic          clk,            // Core clock
	input  wire logic          sys_rst,        // Async reset, active high
	input  wire iod_pkg::iod_op_t op,          // Access class, one cycle
	input  wire logic [7:0]    addr,           // I/O address or data address
	input  wire logic [2:0]    bit_sel,        // Bit for bit ops and skips
	input  wire logic          skip_on_set,    // Skip test polarity
	input  wire logic [7:0]    wdata,          // Write data
	input  wire logic [7:0]    pin_b,          // Raw port B pins
	input  wire logic [7:0]    pin_c,          // Raw port C pins
	input  wire logic [7:0]    pin_d,          // Raw port D pins
	input  wire logic [7:0]    t0_evt,         // Timer0 flag set pulses
	input  wire logic [7:0]    t1_evt,         // Timer1 flag set pulses
	input  wire logic [7:0]    t2_evt,         // Timer2 flag set pulses
	input  wire logic [7:0]    pc_evt,         // Pin-change flag set pulses
	input  wire logic [7:0]    ex_evt,         // External irq flag set pulses
	output logic      [7:0]    rdata,          // Read data, registered
	output logic               rvalid,         // Read data valid pulse
	output logic               skip,           // Skip result pulse
	output logic               ext_sel,        // Access went to extended space
	output logic      [7:0]    port_b_out,     // Port B latch
	output logic      [7:0]    port_b_dir,     // Port B direction
	output logic      [7:0]    port_c_out,     // Port C latch
	output logic      [7:0]    port_c_dir,     // Port C direction
	output logic      [7:0]    port_d_out,     // Port D latch
	output logic      [7:0]    port_d_dir,     // Port D direction
	output logic      [1:0]    ext_irq_mask    // External irq enables
);

	// ****************************************
	// State
	// ****************************************
	logic [7:0] sb1_reg [3];   // First sync stage, read only by second
	logic [7:0] sb2_reg [3];   // Synchronised pin levels
	logic [7:0] lat_reg [3];   // Output latches B, C, D
	logic [7:0] dir_reg [3];   // Direction registers B, C, D
	logic [7:0] lat_next [3];
	logic [7:0] dir_next [3];
	logic [7:0] flg_reg [5];   // Flags: t0, t1, t2, pc, ex
	logic [7:0] flg_next [5];
	logic [7:0] evt [5];       // Event inputs in flag order
	logic [7:0] msk_reg, msk_next;
	logic [7:0] rdata_next;
	logic       rvalid_next, skip_next, ext_next;

	// Decoded access
	logic       is_io;         // Address lands in low 64 I/O locations
	logic [5:0] ioa;           // Effective I/O address
	logic       do_rd, do_wr, do_bit;
	logic [7:0] cur;           // Current value at ioa
	logic [7:0] bitmask;

	// ****************************************
	// Address decode
	// ****************************************
	always_comb begin
		is_io  = 1'b0;
		ioa    = 6'h00;
		do_rd  = 1'b0;
		do_wr  = 1'b0;
		do_bit = 1'b0;
		if (op == iod_pkg::IOD_OP_IN || op == iod_pkg::IOD_OP_OUT) begin
			is_io = 1'b1;
			ioa   = addr[5:0];
			do_rd = (op == iod_pkg::IOD_OP_IN);
			do_wr = (op == iod_pkg::IOD_OP_OUT);
		// data space is I/O address plus offset
		end else if (op == iod_pkg::IOD_OP_LD || op == iod_pkg::IOD_OP_ST) begin
			if (addr >= `IOD_DS_OFFSET && addr <= `IOD_DS_IO_TOP) begin
				is_io = 1'b1;
				ioa   = 6'(addr - `IOD_DS_OFFSET);
				do_rd = (op == iod_pkg::IOD_OP_LD);
				do_wr = (op == iod_pkg::IOD_OP_ST);
			end
		// bit ops only reach the low half
		end else if (op != iod_pkg::IOD_OP_NONE && addr <= 8'(`IOD_BIT_TOP)) begin
			is_io  = 1'b1;
			ioa    = addr[5:0];
			do_bit = (op != iod_pkg::IOD_OP_SKIP);
			do_rd  = (op == iod_pkg::IOD_OP_SKIP);
		end
	end

	assign bitmask = 8'h01 << bit_sel;

	// ****************************************
	// Read mux; unused bits and holes read zero
	// ****************************************
	always_comb begin
		cur = 8'h00;
		if (!is_io) begin
			cur = 8'h00;
		end else if (ioa == `IOD_B_IN_ADDR) begin
			cur = sb2_reg[0];
		end else if (ioa == `IOD_B_DIR_ADDR) begin
			cur = dir_reg[0];
		end else if (ioa == `IOD_B_LAT_ADDR) begin
			cur = lat_reg[0];
		end else if (ioa == `IOD_C_IN_ADDR) begin
			cur = sb2_reg[1] & `IOD_C_MASK;
		end else if (ioa == `IOD_C_DIR_ADDR) begin
			cur = dir_reg[1];
		end else if (ioa == `IOD_C_LAT_ADDR) begin
			cur = lat_reg[1];
		end else if (ioa == `IOD_D_IN_ADDR) begin
			cur = sb2_reg[2];
		end else if (ioa == `IOD_D_DIR_ADDR) begin
			cur = dir_reg[2];
		end else if (ioa == `IOD_D_LAT_ADDR) begin
			cur = lat_reg[2];
		end else if (ioa == `IOD_T0FLG_ADDR) begin
			cur = flg_reg[0];
		end else if (ioa == `IOD_T1FLG_ADDR) begin
			cur = flg_reg[1];
		end else if (ioa == `IOD_T2FLG_ADDR) begin
			cur = flg_reg[2];
		end else if (ioa == `IOD_PCFLG_ADDR) begin
			cur = flg_reg[3];
		end else if (ioa == `IOD_EXFLG_ADDR) begin
			cur = flg_reg[4];
		end else if (ioa == `IOD_EXMSK_ADDR) begin
			cur = msk_reg;
		end
	end

	assign evt[0] = t0_evt;
	assign evt[1] = t1_evt;
	assign evt[2] = t2_evt;
	assign evt[3] = pc_evt;
	assign evt[4] = ex_evt;

	// ****************************************
	// Next-state for ports, mask, flags, answers
	// ****************************************
	always_comb begin
		logic [7:0] wv;     // Whole-register write value
		logic [7:0] clr;    // Ones to clear in flag registers
		logic [7:0] fmask [5];
		logic [5:0] faddr [5];
		logic [7:0] pmask [3];
		logic [5:0] laddr [3];
		logic [5:0] daddr [3];
		wv  = 8'h00;
		clr = 8'h00;
		fmask[0] = `IOD_TMR_MASK;
		fmask[1] = `IOD_T1_MASK;
		fmask[2] = `IOD_TMR_MASK;
		fmask[3] = `IOD_PC_MASK;
		fmask[4] = `IOD_EX_MASK;
		faddr[0] = `IOD_T0FLG_ADDR;
		faddr[1] = `IOD_T1FLG_ADDR;
		faddr[2] = `IOD_T2FLG_ADDR;
		faddr[3] = `IOD_PCFLG_ADDR;
		faddr[4] = `IOD_EXFLG_ADDR;
		pmask[0] = 8'hff;
		pmask[1] = `IOD_C_MASK;
		pmask[2] = 8'hff;
		laddr[0] = `IOD_B_LAT_ADDR;
		laddr[1] = `IOD_C_LAT_ADDR;
		laddr[2] = `IOD_D_LAT_ADDR;
		daddr[0] = `IOD_B_DIR_ADDR;
		daddr[1] = `IOD_C_DIR_ADDR;
		daddr[2] = `IOD_D_DIR_ADDR;
		// bit ops change the addressed bit only
		if (op == iod_pkg::IOD_OP_BSET) begin
			wv  = cur | bitmask;
			clr = bitmask;
		end else if (op == iod_pkg::IOD_OP_BCLR) begin
			wv  = cur & ~bitmask;
			clr = 8'h00;
		end else begin
			wv  = wdata;
			clr = wdata;
		end
		for (int i = 0; i < 3; i++) begin
			lat_next[i] = lat_reg[i];
			dir_next[i] = dir_reg[i];
			if ((do_wr || do_bit) && ioa == laddr[i]) begin
				lat_next[i] = wv & pmask[i];
			end
			if ((do_wr || do_bit) && ioa == daddr[i]) begin
				dir_next[i] = wv & pmask[i];
			end
		end
		msk_next = msk_reg;
		if ((do_wr || do_bit) && ioa == `IOD_EXMSK_ADDR) begin
			msk_next = wv & `IOD_EX_MASK;
		end
		for (int i = 0; i < 5; i++) begin
			flg_next[i] = flg_reg[i];
			// writing one clears, zero leaves the flag
			if ((do_wr || do_bit) && ioa == faddr[i]) begin
				flg_next[i] = flg_next[i] & ~clr;
			end
			// New events win over a clear in the same cycle
			flg_next[i] = (flg_next[i] | evt[i]) & fmask[i];
		end
		rdata_next  = do_rd ? cur : 8'h00;
		rvalid_next = do_rd;
		// skip tests look at one selected bit
		skip_next   = (op == iod_pkg::IOD_OP_SKIP) && is_io && ((cur[bit_sel]) == skip_on_set);
		ext_next    = (op == iod_pkg::IOD_OP_LD || op == iod_pkg::IOD_OP_ST) && addr >= `IOD_EXT_BASE;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 3; i++) begin
				sb1_reg[i] <= `IOD_RST_VAL;
				sb2_reg[i] <= `IOD_RST_VAL;
				lat_reg[i] <= `IOD_RST_VAL;
				dir_reg[i] <= `IOD_RST_VAL;
			end
			for (int i = 0; i < 5; i++) begin
				flg_reg[i] <= `IOD_RST_VAL;
			end
			msk_reg <= `IOD_RST_VAL;
			rdata   <= 8'h00;
			rvalid  <= 1'b0;
			skip    <= 1'b0;
			ext_sel <= 1'b0;
		end else begin
			sb1_reg[0] <= pin_b;
			sb1_reg[1] <= pin_c;
			sb1_reg[2] <= pin_d;
			for (int i = 0; i < 3; i++) begin
				sb2_reg[i] <= sb1_reg[i];
				lat_reg[i] <= lat_next[i];
				dir_reg[i] <= dir_next[i];
			end
			for (int i = 0; i < 5; i++) begin
				flg_reg[i] <= flg_next[i];
			end
			msk_reg <= msk_next;
			rdata   <= rdata_next;
			rvalid  <= rvalid_next;
			skip    <= skip_next;
			ext_sel <= ext_next;
		end
	end

	assign port_b_out   = lat_reg[0];
	assign port_b_dir   = dir_reg[0];
	assign port_c_out   = lat_reg[1];
	assign port_c_dir   = dir_reg[1];
	assign port_d_out   = lat_reg[2];
	assign port_d_dir   = dir_reg[2];
	assign ext_irq_mask = msk_reg[1:0];

	// ****************************************
	// Checks
	// ****************************************
	a_bitop_range: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_BSET && addr > 8'(`IOD_BIT_TOP)) |=> $stable({lat_reg[0], dir_reg[0], msk_reg}))
		else $error("bit op beyond low half changed a register");
	a_ds_offset: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_ST && addr == 8'h25) |=> port_b_out == $past(wdata))
		else $error("store to data address did not reach port latch");
	a_w1c_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_OUT && addr[5:0] == `IOD_EXFLG_ADDR && wdata[0] && !ex_evt[0])
		|=> !flg_reg[4][0])
		else $error("write one did not clear flag");
	a_bset_only: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_BSET && addr[5:0] == `IOD_EXFLG_ADDR && bit_sel == 3'h1 && !ex_evt[0])
		|=> flg_reg[4][0] == $past(flg_reg[4][0]))
		else $error("bit op cleared a neighbour flag");
	a_skip_read: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_SKIP && addr[5:0] == `IOD_B_LAT_ADDR && addr[7:6] == 2'b00)
		|=> skip == ($past(lat_reg[0][bit_sel]) == $past(skip_on_set)))
		else $error("skip result wrong");
	a_ext_space: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_LD && addr >= `IOD_EXT_BASE) |=> ext_sel && !rvalid)
		else $error("extended access not routed");
	a_hole_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_IN && addr[5:0] == 6'h10) |=> rvalid && rdata == 8'h00)
		else $error("reserved address read nonzero");
	a_flag_bits: assert property (@(posedge clk) disable iff (sys_rst)
		(flg_reg[1] & ~`IOD_T1_MASK) == 8'h00 && (flg_reg[3] & ~`IOD_PC_MASK) == 8'h00)
		else $error("unused flag bit set");
	// Named step: a direct read request
	sequence s_in_req;
		op == iod_pkg::IOD_OP_IN;
	endsequence
	a_in_answer: assert property (@(posedge clk) disable iff (sys_rst)
		s_in_req |=> rvalid && !ext_sel && !skip)
		else $error("direct read not answered");
	a_bclr_keep: assert property (@(posedge clk) disable iff (sys_rst)
		(op == iod_pkg::IOD_OP_BCLR && addr == 8'(`IOD_EXFLG_ADDR) && ex_evt == 8'h00)
		|=> $stable(flg_reg[4]))
		else $error("bit clear changed a flag register");
	a_port_c_top: assert property (@(posedge clk) disable iff (sys_rst)
		!port_c_out[7] && !port_c_dir[7])
		else $error("unused port C bit set");
endmodule
